//--- inc/ilsb_consts.svh
// constants of the instruction latency scoreboard
`ifndef ILSB_CONSTS_SVH
`define ILSB_CONSTS_SVH

// result latencies in cycles after issue
`define ILSB_LAT_ONE 6'h01
`define ILSB_LAT_COND_MOVE 6'h02
`define ILSB_LAT_LOAD 6'h02
`define ILSB_LAT_CCREAD 6'h02
`define ILSB_LAT_FLOAT 6'h04
`define ILSB_LAT_MULL 6'h08
`define ILSB_LAT_MULQ 6'h0C
`define ILSB_LAT_MULH 6'h0E
// multiplier repeat intervals
`define ILSB_REP_MULL 6'h04
`define ILSB_REP_MULQH 6'h08
// extra cycles before a result reaches the multiplier
`define ILSB_MX_SINGLE 2'h2
`define ILSB_MX_OTHER 2'h1
`define ILSB_MX_NONE 2'h0
// floating divide latency limits
`define ILSB_DIV_S_MIN 6'h0F
`define ILSB_DIV_S_MAX 6'h1F
`define ILSB_DIV_D_MIN 6'h16
`define ILSB_DIV_D_MAX 6'h3C
// branch, second-level cache and scoreboard figures
`define ILSB_MISPREDICT 3'h5
`define ILSB_L2_HIT_LAT 6'h08
`define ILSB_WAIT_FILL 6'h3F
`define ILSB_ZERO_INT 6'h1F
`define ILSB_ZERO_FLT 6'h3F

`endif

//--- inc/ilsb_pkg.sv
// types of the instruction latency scoreboard
package ilsb_pkg;

  // instruction classes seen at the issue point
  typedef enum logic [4:0] {
    CLS_NONE = 5'h00,
    CLS_FLOAT_BRANCH = 5'h01,
    CLS_INT_BRANCH = 5'h02,
    CLS_JUMP = 5'h03,
    CLS_PRIV_RETURN = 5'h04,
    CLS_SIGN_EXTEND = 5'h05,
    CLS_INT_ADD = 5'h06,
    CLS_INT_LOGIC = 5'h07,
    CLS_SHIFT = 5'h08,
    CLS_COND_MOVE = 5'h09,
    CLS_INT_COMPARE = 5'h0A,
    CLS_MUL_LONG = 5'h0B,
    CLS_MUL_QUAD = 5'h0C,
    CLS_MUL_UPPER = 5'h0D,
    CLS_FLOAT_ADD = 5'h0E,
    CLS_FLOAT_DIVIDE = 5'h0F,
    CLS_FLOAT_MUL = 5'h10,
    CLS_FLOAT_COPY_SIGN = 5'h11,
    CLS_CYCLE_COUNT_READ = 5'h12,
    CLS_TRAP_BARRIER = 5'h13,
    CLS_UNIVERSAL_NOOP = 5'h14,
    CLS_LOAD = 5'h15
  } ilsb_class_e;

  // second-level cache arbiter states
  typedef enum logic {
    ARB_IDLE = 1'b0,
    ARB_BUSY = 1'b1
  } ilsb_arb_e;

  typedef logic [5:0] ilsb_count_t;
  typedef logic [5:0] ilsb_reg_t;

  // whole state of the scoreboard
  typedef struct packed {
    logic [63:0][5:0] readyCnt;
    logic [63:0][1:0] mulExtra;
    ilsb_count_t mulBusy;
    ilsb_count_t divBusy;
    logic [2:0] penalty;
    ilsb_arb_e arb;
    ilsb_count_t arbCnt;
    ilsb_reg_t arbReg;
    logic l2Request;
    ilsb_count_t mulLatency;
  } ilsb_state_s;

endpackage : ilsb_pkg

//--- design/ilsb_scoreboard.sv
// issue-stage latency scoreboard for two in-order issue slots
`timescale 1ns/1ps
`default_nettype none
`include "ilsb_consts.svh"

module ilsb_scoreboard (
  input wire logic mclk,
  input wire logic reset,
  input wire logic slotValidA,
  input wire ilsb_pkg::ilsb_class_e slotClassA,
  input wire ilsb_pkg::ilsb_reg_t destA,
  input wire ilsb_pkg::ilsb_reg_t testSrcA,
  input wire ilsb_pkg::ilsb_reg_t otherSrcA,
  input wire ilsb_pkg::ilsb_count_t divLatencyA,
  input wire logic divDoubleA,
  input wire logic predTakenA,
  input wire logic slotValidB,
  input wire ilsb_pkg::ilsb_class_e slotClassB,
  input wire ilsb_pkg::ilsb_reg_t destB,
  input wire ilsb_pkg::ilsb_reg_t testSrcB,
  input wire ilsb_pkg::ilsb_reg_t otherSrcB,
  input wire ilsb_pkg::ilsb_count_t divLatencyB,
  input wire logic divDoubleB,
  input wire logic mispredict,
  input wire logic loadMissPipeZero,
  input wire ilsb_pkg::ilsb_reg_t loadMissReg,
  input wire logic cacheBoxEvent,
  input wire logic l2SlowPath,
  input wire logic fillValid,
  input wire ilsb_pkg::ilsb_reg_t fillReg,
  output logic issueA,
  output logic issueB,
  output logic l2Request,
  output ilsb_pkg::ilsb_reg_t l2RequestReg,
  output ilsb_pkg::ilsb_count_t mulLatency,
  output logic mulBusy,
  output logic divBusy
);
  import ilsb_pkg::*;

  ilsb_state_s state_r;
  ilsb_state_s state_nxt;

  // ****************************************************************
  // class properties
  // ****************************************************************

  // result latency of a class; zero means no register result, except a divide, whose latency comes from div_clamp
  function automatic ilsb_count_t class_latency(input ilsb_class_e c);
    ilsb_count_t lat;
    lat = 6'h00;
    unique case (c)
      CLS_JUMP, CLS_SIGN_EXTEND, CLS_INT_ADD, CLS_SHIFT:
        lat = `ILSB_LAT_ONE;
      CLS_INT_LOGIC, CLS_INT_COMPARE: lat = `ILSB_LAT_ONE;
      CLS_COND_MOVE: lat = `ILSB_LAT_COND_MOVE;
      CLS_LOAD: lat = `ILSB_LAT_LOAD;
      CLS_CYCLE_COUNT_READ: lat = `ILSB_LAT_CCREAD;
      CLS_FLOAT_ADD, CLS_FLOAT_MUL, CLS_FLOAT_COPY_SIGN:
        lat = `ILSB_LAT_FLOAT;
      CLS_MUL_LONG: lat = `ILSB_LAT_MULL;
      CLS_MUL_QUAD: lat = `ILSB_LAT_MULQ;
      CLS_MUL_UPPER: lat = `ILSB_LAT_MULH;
      // branches, return, barrier, noop write nothing
      CLS_FLOAT_BRANCH, CLS_INT_BRANCH, CLS_PRIV_RETURN,
      CLS_TRAP_BARRIER, CLS_UNIVERSAL_NOOP, CLS_FLOAT_DIVIDE,
      CLS_NONE: lat = 6'h00;
      default: lat = 6'h00;
    endcase
    return lat;
  endfunction : class_latency

  // extra cycles before the result can be read by the multiplier
  function automatic logic [1:0] class_mul_extra(input ilsb_class_e c);
    logic [1:0] mx;
    mx = `ILSB_MX_NONE;
    unique case (c)
      CLS_JUMP, CLS_SIGN_EXTEND, CLS_INT_ADD, CLS_INT_LOGIC,
      CLS_SHIFT, CLS_INT_COMPARE: mx = `ILSB_MX_SINGLE;
      CLS_COND_MOVE, CLS_LOAD, CLS_CYCLE_COUNT_READ,
      CLS_MUL_LONG, CLS_MUL_QUAD, CLS_MUL_UPPER:
        mx = `ILSB_MX_OTHER;
      default: mx = `ILSB_MX_NONE;
    endcase
    return mx;
  endfunction : class_mul_extra

  function automatic logic is_mul(input ilsb_class_e c);
    return (c == CLS_MUL_LONG) || (c == CLS_MUL_QUAD) ||
           (c == CLS_MUL_UPPER);
  endfunction : is_mul

  // classes that read no register and so create no dependency
  function automatic logic reads_none(input ilsb_class_e c);
    return (c == CLS_UNIVERSAL_NOOP) || (c == CLS_TRAP_BARRIER) ||
           (c == CLS_NONE);
  endfunction : reads_none

  // hard-wired zero registers never become pending
  function automatic logic is_zero_reg(input ilsb_reg_t r);
    return (r == `ILSB_ZERO_INT) || (r == `ILSB_ZERO_FLT);
  endfunction : is_zero_reg

  // divide latency held inside the documented range
  function automatic ilsb_count_t div_clamp(input ilsb_count_t l,
                                            input logic dbl);
    ilsb_count_t lo;
    ilsb_count_t hi;
    lo = dbl ? `ILSB_DIV_D_MIN : `ILSB_DIV_S_MIN;
    hi = dbl ? `ILSB_DIV_D_MAX : `ILSB_DIV_S_MAX;
    if (l < lo) begin
      return lo;
    end
    if (l > hi) begin
      return hi;
    end
    return l;
  endfunction : div_clamp

  // ****************************************************************
  // issue decision
  // ****************************************************************

  logic readyTestA, readyOtherA, readyDestA;
  logic readyTestB, readyOtherB, readyDestB;
  logic bypassB, depOnA, unitClashB, canA, canB;
  logic [1:0] addedA, addedB;

  // a register is readable once its countdown has reached zero
  always_comb begin
    readyTestA = (state_r.readyCnt[testSrcA] == 6'h00);
    readyOtherA = (state_r.readyCnt[otherSrcA] == 6'h00);
    readyDestA = (state_r.readyCnt[destA] == 6'h00);
    readyTestB = (state_r.readyCnt[testSrcB] == 6'h00);
    readyOtherB = (state_r.readyCnt[otherSrcB] == 6'h00);
    readyDestB = (state_r.readyCnt[destB] == 6'h00);
    // operand delay seen by a multiply: worst of its two sources
    addedA = state_r.mulExtra[testSrcA];
    if (state_r.mulExtra[otherSrcA] > addedA) begin
      addedA = state_r.mulExtra[otherSrcA];
    end
    addedB = state_r.mulExtra[testSrcB];
    if (state_r.mulExtra[otherSrcB] > addedB) begin
      addedB = state_r.mulExtra[otherSrcB];
    end
  end

  // slot A: older instruction
  always_comb begin
    canA = slotValidA && (state_r.penalty == 3'h0);
    if (!reads_none(slotClassA)) begin
      canA = canA && readyTestA && readyOtherA && readyDestA;
    end
    if (is_mul(slotClassA)) begin
      canA = canA && (state_r.mulBusy == 6'h00);
    end
    if (slotClassA == CLS_FLOAT_DIVIDE) begin
      canA = canA && (state_r.divBusy == 6'h00);
    end
  end

  // slot B: issues only beside an issuing A
  always_comb begin
    bypassB = ((slotClassA == CLS_INT_COMPARE) ||
               (slotClassA == CLS_INT_LOGIC)) &&
              ((slotClassB == CLS_INT_BRANCH) ||
               (slotClassB == CLS_COND_MOVE)) &&
              (testSrcB == destA) && (otherSrcB != destA);
    depOnA = (class_latency(slotClassA) != 6'h00) &&
             !is_zero_reg(destA) &&
             ((testSrcB == destA) || (otherSrcB == destA) ||
              (destB == destA));
    unitClashB = (is_mul(slotClassA) && is_mul(slotClassB)) ||
                 ((slotClassA == CLS_FLOAT_DIVIDE) &&
                  (slotClassB == CLS_FLOAT_DIVIDE));
    canB = slotValidB && canA && !predTakenA && !unitClashB;
    if (!reads_none(slotClassB)) begin
      canB = canB && readyOtherB && readyDestB;
      canB = canB && (readyTestB || bypassB);
      canB = canB && (!depOnA || bypassB);
    end
    if (is_mul(slotClassB)) begin
      canB = canB && (state_r.mulBusy == 6'h00);
    end
    if (slotClassB == CLS_FLOAT_DIVIDE) begin
      canB = canB && (state_r.divBusy == 6'h00);
    end
  end

  assign issueA = canA;
  assign issueB = canB;

  // ****************************************************************
  // next state
  // ****************************************************************

  // record one issued instruction into the scoreboard
  function automatic ilsb_state_s record(input ilsb_state_s s,
                                         input ilsb_class_e c,
                                         input ilsb_reg_t d,
                                         input logic [1:0] added,
                                         input ilsb_count_t divLat,
                                         input logic dbl);
    ilsb_count_t lat;
    ilsb_count_t rep;
    lat = class_latency(c);
    rep = (c == CLS_MUL_LONG) ? `ILSB_REP_MULL : `ILSB_REP_MULQH;
    if (is_mul(c)) begin
      lat = lat + {4'h0, added};
      s.mulBusy = rep + {4'h0, added} - 6'h01;
      s.mulLatency = lat;
    end
    if (c == CLS_FLOAT_DIVIDE) begin
      lat = div_clamp(divLat, dbl);
      s.divBusy = lat - 6'h01;
    end
    if ((lat != 6'h00) && !is_zero_reg(d)) begin
      s.readyCnt[d] = lat - 6'h01;
      s.mulExtra[d] = class_mul_extra(c);
    end
    return s;
  endfunction : record

  always_comb begin
    state_nxt = state_r;
    state_nxt.l2Request = 1'b0;
    // count every pending register down; fill waits do not move
    for (int i = 0; i < 64; i++) begin
      if (state_r.readyCnt[i] == `ILSB_WAIT_FILL) begin
        state_nxt.readyCnt[i] = `ILSB_WAIT_FILL;
      end else if (state_r.readyCnt[i] != 6'h00) begin
        state_nxt.readyCnt[i] = state_r.readyCnt[i] - 6'h01;
      end else if (state_r.mulExtra[i] != 2'h0) begin
        state_nxt.mulExtra[i] = state_r.mulExtra[i] - 2'h1;
      end
    end
    // unit repeat counters
    if (state_r.mulBusy != 6'h00) begin
      state_nxt.mulBusy = state_r.mulBusy - 6'h01;
    end
    if (state_r.divBusy != 6'h00) begin
      state_nxt.divBusy = state_r.divBusy - 6'h01;
    end
    // mispredict blocks issue for the penalty time
    if (mispredict) begin
      state_nxt.penalty = `ILSB_MISPREDICT;
    end else if (state_r.penalty != 3'h0) begin
      state_nxt.penalty = state_r.penalty - 3'h1;
    end
    // issued instructions, older first
    if (canA) begin
      state_nxt = record(state_nxt, slotClassA, destA, addedA,
                         divLatencyA, divDoubleA);
    end
    if (canB) begin
      state_nxt = record(state_nxt, slotClassB, destB, addedB,
                         divLatencyB, divDoubleB);
    end
    // second-level cache arbiter
    unique case (state_r.arb)
      ARB_IDLE: begin
        if (loadMissPipeZero && !is_zero_reg(loadMissReg)) begin
          if (!cacheBoxEvent) begin
            // predicted miss goes straight to the cache
            state_nxt.l2Request = 1'b1;
            state_nxt.arbReg = loadMissReg;
            state_nxt.arb = ARB_BUSY;
            state_nxt.arbCnt = `ILSB_L2_HIT_LAT - 6'h01;
            state_nxt.readyCnt[loadMissReg] =
              `ILSB_L2_HIT_LAT - 6'h01;
          end else begin
            state_nxt.readyCnt[loadMissReg] = `ILSB_WAIT_FILL;
          end
          state_nxt.mulExtra[loadMissReg] = `ILSB_MX_OTHER;
        end
      end
      ARB_BUSY: begin
        if (state_r.arbCnt != 6'h00) begin
          state_nxt.arbCnt = state_r.arbCnt - 6'h01;
        end else begin
          state_nxt.arb = ARB_IDLE;
        end
        // interference or a cache miss pushes the load to the fill
        if (l2SlowPath) begin
          state_nxt.readyCnt[state_r.arbReg] = `ILSB_WAIT_FILL;
          state_nxt.arb = ARB_IDLE;
        end
        // misses while busy wait for their fill
        if (loadMissPipeZero && !is_zero_reg(loadMissReg)) begin
          state_nxt.readyCnt[loadMissReg] = `ILSB_WAIT_FILL;
          state_nxt.mulExtra[loadMissReg] = `ILSB_MX_OTHER;
        end
      end
    endcase
    // fill data makes its register readable
    if (fillValid && !is_zero_reg(fillReg)) begin
      state_nxt.readyCnt[fillReg] = 6'h00;
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************

  // synchronous reset clears every pending result
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  // outputs from flip-flops
  assign l2Request = state_r.l2Request;
  assign l2RequestReg = state_r.arbReg;
  assign mulLatency = state_r.mulLatency;
  assign mulBusy = (state_r.mulBusy != 6'h00);
  assign divBusy = (state_r.divBusy != 6'h00);

endmodule : ilsb_scoreboard
`default_nettype wire

//--- verification/ilsb_scoreboard_assertions.sv
// port checks of the latency scoreboard, bound to its top module
`timescale 1ns/1ps
`default_nettype none

module ilsb_checker (
  input wire logic mclk,
  input wire logic reset,
  input wire logic slotValidA,
  input wire ilsb_pkg::ilsb_class_e slotClassA,
  input wire logic predTakenA,
  input wire logic divDoubleA,
  input wire logic mispredict,
  input wire logic loadMissPipeZero,
  input wire ilsb_pkg::ilsb_reg_t loadMissReg,
  input wire logic cacheBoxEvent,
  input wire logic issueA,
  input wire logic issueB,
  input wire logic l2Request,
  input wire ilsb_pkg::ilsb_reg_t l2RequestReg,
  input wire ilsb_pkg::ilsb_count_t mulLatency,
  input wire logic mulBusy,
  input wire logic divBusy
);
  import ilsb_pkg::*;

  // ****************
  // issue, cache request and unit timing checks
  // ****************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  // shortest busy span of a single-precision divide
  sequence divMinBusy;
    divBusy [*7] ##1 divBusy [*7];
  endsequence

  // older slot holds a multiply
  logic isMulA;
  assign isMulA = slotClassA inside
    {CLS_MUL_LONG, CLS_MUL_QUAD, CLS_MUL_UPPER};

  mispr_block_a: assert property (mispredict |=> !issueA [*5])
    else $error("issue inside mispredict penalty");
  taken_alone_a: assert property (issueA && predTakenA |-> !issueB)
    else $error("young slot issued past a taken branch");
  young_order_a: assert property (issueB |-> issueA)
    else $error("young slot issued without the old one");
  miss_cause_a: assert property (
    l2Request |-> $past(loadMissPipeZero) && !$past(cacheBoxEvent) &&
    l2RequestReg == $past(loadMissReg))
    else $error("cache request without an idle pipe-zero miss");
  miss_pulse_a: assert property (l2Request |=> !l2Request)
    else $error("cache request longer than one cycle");
  mull_time_a: assert property (
    issueA && slotClassA == CLS_MUL_LONG |=>
    (mulLatency inside {[6'h08:6'h0A]}) and (mulBusy [*3]))
    else $error("longword multiply timing wrong");
  mulq_time_a: assert property (
    issueA && slotClassA == CLS_MUL_QUAD |=>
    (mulLatency inside {[6'h0C:6'h0E]}) and (mulBusy [*7]))
    else $error("quadword multiply timing wrong");
  mulh_time_a: assert property (
    issueA && slotClassA == CLS_MUL_UPPER |=>
    (mulLatency inside {[6'h0E:6'h10]}) and (mulBusy [*7]))
    else $error("upper multiply timing wrong");
  mul_hold_a: assert property (
    mulBusy && slotValidA && isMulA |-> !issueA)
    else $error("multiply issued to a busy multiplier");
  div_span_a: assert property (
    issueA && slotClassA == CLS_FLOAT_DIVIDE && !divDoubleA |=>
    divMinBusy ##[1:17] !divBusy)
    else $error("single divide busy span out of range");
endmodule : ilsb_checker

bind ilsb_scoreboard ilsb_checker i_chk (.*);

`default_nettype wire

//--- verification/ilsb_tb.sv
// self-checking bench of the latency scoreboard
`timescale 1ns/1ps
`default_nettype none

module tb;
  import ilsb_pkg::*;

  // ****************
  // bench state
  // ****************
  logic mclk, reset, slotValidA, divDoubleA, predTakenA, slotValidB;
  logic divDoubleB, mispredict, loadMissPipeZero, cacheBoxEvent;
  logic l2SlowPath, fillValid, issueA, issueB, l2Request, mulBusy;
  logic divBusy, mulPend, gB, gTk, gDd;
  ilsb_class_e slotClassA, slotClassB, gBc;
  ilsb_reg_t destA, testSrcA, otherSrcA, destB, testSrcB, otherSrcB;
  ilsb_reg_t loadMissReg, fillReg, l2RequestReg, gTs;
  ilsb_count_t divLatencyA, divLatencyB, mulLatency, gDl;
  logic [31:0] qA[$], qB[$], qM[$], qL[$], seed;
  int cyc, lastA, pAt, numErrors, nTests;
  ilsb_class_e pc[15];
  int pl[15];

  ilsb_scoreboard i_dut (.*);

  // free-running clock
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // xorshift source of register numbers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    nTests++;
    if (got !== exp) begin
      numErrors++;
      $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : cmp

  // oldest note against a result; all ones marks an unchecked note
  task automatic take(ref logic [31:0] q[$], input logic [31:0] got);
    logic [31:0] e;
    e = 32'hFFFF_FFFE;
    if (q.size() > 0) e = q.pop_front();
    if (e !== 32'hFFFF_FFFF) cmp(got, e);
  endtask : take

  task automatic closeOut();
    numErrors += qA.size() + qB.size() + qM.size() + qL.size();
    $display("compares %0d, mismatches %0d", nTests, numErrors);
    if (numErrors == 0 && nTests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : closeOut

  // present one issue group and hold it until the old slot issues
  task automatic put(input ilsb_class_e c, input ilsb_reg_t d, s1, s2,
                     input int e);
    int n;
    @(negedge mclk);
    slotValidA = 1'b1;
    slotClassA = c;
    destA = d;
    testSrcA = s1;
    otherSrcA = s2;
    divLatencyA = gDl;
    divDoubleA = gDd;
    predTakenA = gTk;
    slotValidB = gB;
    slotClassB = gBc;
    testSrcB = gTs;
    mispredict = 1'b0;
    loadMissPipeZero = 1'b0;
    cacheBoxEvent = 1'b0;
    qA.push_back(e);
    if (gB && !gTk) qB.push_back(32'(gBc));
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (issueA !== 1'b1 && n < 300);
    #1;
    if (n >= 300) begin
      numErrors++;
      closeOut();
    end else begin
      pAt = lastA;
    end
  endtask : put

  // pipe-zero miss, then a consumer; slow or refused misses need a fill
  task automatic lmiss(input ilsb_reg_t r, input logic cbe, input logic sl);
    int m;
    @(negedge mclk);
    slotValidA = 1'b0;
    loadMissPipeZero = 1'b1;
    loadMissReg = r;
    cacheBoxEvent = cbe;
    if (!cbe) qL.push_back(32'(r));
    @(posedge mclk);
    #1;
    m = cyc - 1;
    fork
      begin
        repeat (2) @(negedge mclk);
        l2SlowPath = sl;
        @(negedge mclk);
        l2SlowPath = 1'b0;
        repeat (27) @(negedge mclk);
        fillValid = cbe | sl;
        fillReg = r;
        @(negedge mclk);
        fillValid = 1'b0;
      end
    join_none
    put(CLS_INT_ADD, 6'h15, r, 6'h1F, (cbe | sl) ? m + 31 : m + 8);
  endtask : lmiss

  // result watcher: issue cycles, young classes, multiply latency, misses
  always @(posedge mclk) begin
    if (reset === 1'b0) begin
      if (mulPend) take(qM, 32'(mulLatency));
      if (issueA === 1'b1) take(qA, cyc);
      if (issueA === 1'b1) lastA = cyc;
      if (issueB === 1'b1) take(qB, 32'(slotClassB));
      if (l2Request === 1'b1) take(qL, 32'(l2RequestReg));
      mulPend = issueA === 1'b1 &&
        slotClassA inside {CLS_MUL_LONG, CLS_MUL_QUAD, CLS_MUL_UPPER};
    end
    cyc++;
  end

  // main sequence
  initial begin
    ilsb_reg_t r;
    int p;
    ilsb_class_e c;
    seed = 32'h0000_0010;
    pc = '{CLS_INT_ADD, CLS_INT_LOGIC, CLS_INT_COMPARE, CLS_SIGN_EXTEND,
           CLS_SHIFT, CLS_JUMP, CLS_COND_MOVE, CLS_CYCLE_COUNT_READ,
           CLS_PRIV_RETURN, CLS_TRAP_BARRIER, CLS_UNIVERSAL_NOOP,
           CLS_FLOAT_BRANCH, CLS_FLOAT_ADD, CLS_FLOAT_MUL,
           CLS_FLOAT_COPY_SIGN};
    pl = '{1, 1, 1, 1, 1, 1, 2, 2, 0, 0, 0, 0, 4, 4, 4};
    reset = 1'b1;
    {slotValidA, slotValidB, divDoubleA, divDoubleB, predTakenA} = '0;
    {mispredict, loadMissPipeZero, cacheBoxEvent, l2SlowPath} = '0;
    {fillValid, gB, gTk, gDd, mulPend, cyc, numErrors, nTests} = '0;
    {divLatencyA, divLatencyB, gDl, fillReg, loadMissReg, gTs} = '0;
    {destA, testSrcA, otherSrcA, destB, otherSrcB} = {5{6'h1F}};
    testSrcB = 6'h06;
    slotClassA = CLS_NONE;
    slotClassB = CLS_NONE;
    gBc = CLS_NONE;
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    reset = 1'b0;
    cmp(32'({l2Request, mulBusy, divBusy, mulLatency}), 32'h0000_0000);
    gBc = CLS_INT_ADD;
    for (int i = 0; i < 15; i++) begin
      r = 6'(rnd() % 18 + 1) + (i > 11 ? 6'h20 : 6'h00);
      // a class with no result lets a young reader of it pair up at once
      gB = (pl[i] == 0);
      gTs = r;
      put(pc[i], r, 6'h1F, 6'h1F, -1);
      gB = 1'b0;
      p = pAt + (pl[i] > 0 ? pl[i] : 1);
      c = i > 11 ? CLS_FLOAT_ADD : CLS_INT_ADD;
      put(c, 6'h14, r, 6'h1F, p);
    end
    $display("test class latencies done");
    gB = 1'b1;
    gTs = 6'h06;
    r = 6'h1F;
    for (int i = 0; i < 4; i++) begin
      gBc = i[1] ? CLS_COND_MOVE : CLS_INT_BRANCH;
      put(i[0] ? CLS_INT_LOGIC : CLS_INT_COMPARE, 6'h06, r, r, -1);
    end
    gTk = 1'b1;
    gBc = CLS_INT_ADD;
    put(CLS_FLOAT_BRANCH, 6'h1F, 6'h1F, 6'h1F, -1);
    gB = 1'b0;
    gTk = 1'b0;
    @(negedge mclk);
    slotValidA = 1'b0;
    mispredict = 1'b1;
    @(posedge mclk);
    #1;
    put(CLS_INT_ADD, 6'h0A, 6'h1F, 6'h1F, cyc + 5);
    $display("test bypass and branches done");
    put(CLS_INT_ADD, 6'h05, 6'h1F, 6'h1F, -1);
    qM.push_back(10);
    put(CLS_MUL_LONG, 6'h07, 6'h05, 6'h1F, pAt + 1);
    qM.push_back(12);
    put(CLS_MUL_QUAD, 6'h08, 6'h1F, 6'h1F, pAt + 6);
    qM.push_back(14);
    put(CLS_MUL_UPPER, 6'h09, 6'h1F, 6'h1F, pAt + 8);
    put(CLS_INT_ADD, 6'h0A, 6'h09, 6'h1F, pAt + 14);
    put(CLS_INT_ADD, 6'h05, 6'h1F, 6'h1F, -1);
    put(CLS_UNIVERSAL_NOOP, 6'h1F, 6'h1F, 6'h1F, pAt + 1);
    qM.push_back(9);
    put(CLS_MUL_LONG, 6'h07, 6'h05, 6'h1F, pAt + 1);
    put(CLS_INT_ADD, 6'h0B, 6'h07, 6'h1F, pAt + 9);
    $display("test multiplier done");
    r = 6'h3F;
    p = -1;
    for (int i = 0; i < 4; i++) begin
      gDd = i[1];
      gDl = i[0] ? (i[1] ? 6'h3C : 6'h1F) : (i[1] ? 6'h16 : 6'h0F);
      put(CLS_FLOAT_DIVIDE, 6'h28 + 6'(i), r, 6'h3F, p);
      p = pAt + gDl;
      r = 6'h28 + 6'(i);
    end
    put(CLS_FLOAT_ADD, 6'h32, r, 6'h3F, p);
    $display("test divider done");
    lmiss(6'h0C, 1'b0, 1'b0);
    lmiss(6'h0D, 1'b1, 1'b0);
    lmiss(6'h0E, 1'b0, 1'b1);
    $display("test load miss done");
    closeOut();
  end
endmodule : tb

`default_nettype wire
